// ==== ocs_clock_select.sv ====
`include "ocs_regs.svh"

// Contract
// - Oscillator enable from system unit gates the selected source oscillator.
// - Clock x4 output is the selected source clock itself, undivided.
// - Clock x2 output runs at half the x4 frequency.
// - Wait mode leaves both output clocks running.
// - Stop mode halts the source output, hence both derived clocks.
// - Break state leaves both output clocks running.
// - Select 00 internal, 01 external input, 10 RC, 11 crystal.
// - Generator enable bit at 0x36 is read/write, starts switching, reset clears.
// - Generator enable ignored in monitor bypass and both factory test modes.
// - Engaged status bit reads 1 while external clock drives the system.
// - Trim value sets internal period; each step about 0.2 percent.
// - Wait two external rising edges, switch glitch-free, set status, stop internal.
// - After switching, only reset restores internal; no automatic fallback.
// - Internal or RC selected: second pin outputs x4 when enabled.
module ocs_clock_select (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Register port
   input wire ocs_pkg::ocs_byte_t addr_in,
   input wire ocs_pkg::ocs_byte_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output ocs_pkg::ocs_byte_t rdata_out,
   // System integration unit
   input wire logic osc_enable_from_sysint_in,
   input wire logic stop_mode_in,
   output logic clock_out_x4_out,
   output logic clock_out_x2_out,
   // Configuration and operating modes
   input wire logic source_select_hi_in,
   input wire logic source_select_lo_in,
   input wire logic monitor_bypass_in,
   input wire logic factory_test_mode_a_in,
   input wire logic factory_test_mode_b_in,
   input wire logic pin_clock_output_enable_in,
   // External source clocks
   input wire logic crystal_source_clock_in,
   input wire logic rc_source_clock_in,
   input wire logic ext_clock_pin_in,
   // Oscillator controls
   output logic crystal_osc_enable_out,
   output logic rc_osc_enable_out,
   output logic internal_osc_enable_out,
   output ocs_pkg::ocs_byte_t trim_factor_out,
   output logic internal_source_clock_out,
   // Second oscillator pin
   output logic osc_pin2_out,
   output logic osc_pin2_oe_out
);
   import ocs_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam ocs_core_st_t RST_ST = '{
      ext_gen_enable: 1'b0,
      ext_clock_engaged: 1'b0,
      trim_factor: `OCS_TRIM_RESET,
      sw: SW_INTERNAL,
      int_level: 1'b0,
      int_cnt: 10'h000,
      ext_prev: 1'b0,
      x4: 1'b0,
      x2: 1'b0,
      rdata: `OCS_READ_IDLE
   };

   ocs_core_st_t st_reg;
   ocs_core_st_t st_next;
   logic [1:0] sel;
   logic xtal_sync;
   logic rc_sync;
   logic ext_sync;
   logic ext_level;
   logic ext_rise;
   logic run;
   logic int_run;
   logic src_level;
   logic switch_ignored;
   logic switch_go;
   logic [9:0] half_cycles;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   ocs_sync u_sync_xtal (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .async_in(crystal_source_clock_in),
      .sync_out(xtal_sync)
   );

   ocs_sync u_sync_rc (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .async_in(rc_source_clock_in),
      .sync_out(rc_sync)
   );

   ocs_sync u_sync_ext (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .async_in(ext_clock_pin_in),
      .sync_out(ext_sync)
   );

   // ----------------------------------------------------------------
   // Source selection and gating
   // ----------------------------------------------------------------
   assign sel = {source_select_hi_in, source_select_lo_in};

   assign ext_level = (sel == `OCS_SEL_EXT_INPUT) ? ext_sync :
                      (sel == `OCS_SEL_RC) ? rc_sync :
                      (sel == `OCS_SEL_CRYSTAL) ? xtal_sync : 1'b0;
   assign ext_rise = ext_level & ~st_reg.ext_prev;

   assign run = osc_enable_from_sysint_in & ~stop_mode_in;
   assign int_run = run & ~st_reg.ext_clock_engaged;
   assign src_level = st_reg.ext_clock_engaged ? ext_level : st_reg.int_level;

   assign switch_ignored = monitor_bypass_in | factory_test_mode_a_in |
                           factory_test_mode_b_in;
   assign switch_go = st_reg.ext_gen_enable & ~switch_ignored &
                      (sel != `OCS_SEL_INTERNAL);

   assign half_cycles = 10'(`OCS_INT_HALF_CYC) + {2'h0, st_reg.trim_factor} -
                        `OCS_TRIM_CENTER;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.ext_prev = ext_level;

      // Internal oscillator model, one toggle per trimmed half period
      if (!int_run) begin
         st_next.int_level = 1'b0;
         st_next.int_cnt = 10'h000;
      end else if (st_reg.int_cnt >= half_cycles - `OCS_CNT_ONE) begin
         st_next.int_level = ~st_reg.int_level;
         st_next.int_cnt = 10'h000;
      end else begin
         st_next.int_cnt = st_reg.int_cnt + `OCS_CNT_ONE;
      end

      // Internal to external switch sequence
      case (st_reg.sw)
         SW_INTERNAL: begin
            if (switch_go) begin
               st_next.sw = SW_EDGE_ONE;
            end
         end
         SW_EDGE_ONE: begin
            if (!switch_go) begin
               st_next.sw = SW_INTERNAL;
            end else if (ext_rise) begin
               st_next.sw = SW_EDGE_TWO;
            end
         end
         SW_EDGE_TWO: begin
            if (!switch_go) begin
               st_next.sw = SW_INTERNAL;
            end else if (ext_rise) begin
               st_next.sw = SW_ALIGN;
            end
         end
         SW_ALIGN: begin
            if (!switch_go) begin
               st_next.sw = SW_INTERNAL;
            end else if (!ext_level && !st_reg.int_level) begin
               st_next.ext_clock_engaged = 1'b1;
               st_next.sw = SW_EXTERNAL;
            end
         end
         SW_EXTERNAL: begin
            st_next.sw = SW_EXTERNAL;
         end
         default: begin
            st_next.sw = SW_INTERNAL;
         end
      endcase

      if (run) begin
         st_next.x4 = src_level;
         if (src_level && !st_reg.x4) begin
            st_next.x2 = ~st_reg.x2;
         end
      end else begin
         st_next.x4 = 1'b0;
      end

      if (wr_in) begin
         case (addr_in)
            `OCS_CLOCK_SWITCH_STATUS_ADDR: begin
               st_next.ext_gen_enable = wdata_in[`OCS_GEN_ENABLE_BIT];
            end
            `OCS_INTERNAL_OSC_TRIM_ADDR: begin
               st_next.trim_factor = wdata_in;
            end
            default: begin
            end
         endcase
      end

      st_next.rdata = `OCS_READ_IDLE;
      if (rd_in) begin
         case (addr_in)
            `OCS_CLOCK_SWITCH_STATUS_ADDR: begin
               st_next.rdata[`OCS_GEN_ENABLE_BIT] = st_reg.ext_gen_enable;
               st_next.rdata[`OCS_ENGAGED_BIT] = st_reg.ext_clock_engaged;
            end
            `OCS_INTERNAL_OSC_TRIM_ADDR: begin
               st_next.rdata = st_reg.trim_factor;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Trim reset value
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         st_reg <= RST_ST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rdata_out = st_reg.rdata;
   assign clock_out_x4_out = st_reg.x4;
   assign clock_out_x2_out = st_reg.x2;
   assign trim_factor_out = st_reg.trim_factor;
   assign internal_source_clock_out = st_reg.int_level;

   assign crystal_osc_enable_out = run & (sel == `OCS_SEL_CRYSTAL);
   assign rc_osc_enable_out = run & (sel == `OCS_SEL_RC);
   assign internal_osc_enable_out = int_run;

   assign osc_pin2_oe_out = pin_clock_output_enable_in &
                            ((sel == `OCS_SEL_INTERNAL) | (sel == `OCS_SEL_RC));
   assign osc_pin2_out = st_reg.x4;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in);

   chk_stop_halts_x4: assert property (
      stop_mode_in |=> (clock_out_x4_out == 1'b0))
      else $error("x4 clock still running in stop mode");

   chk_stop_freezes_x2: assert property (
      stop_mode_in |=> $stable(clock_out_x2_out))
      else $error("x2 clock changed in stop mode");

   chk_x2_half_rate: assert property (
      $changed(clock_out_x2_out) == $rose(clock_out_x4_out))
      else $error("x2 toggle not tied to x4 rising edge");

   chk_x4_follows_src: assert property (
      run |=> (clock_out_x4_out == $past(src_level)))
      else $error("x4 clock does not follow selected source");

   chk_int_osc_stopped: assert property (
      st_reg.ext_clock_engaged |=> (!internal_osc_enable_out && !internal_source_clock_out))
      else $error("internal oscillator still running after switch");

   chk_engage_needs_go: assert property (
      $rose(st_reg.ext_clock_engaged) |-> $past(switch_go))
      else $error("engaged while switching was not allowed");

   chk_engage_after_edges: assert property (
      $rose(st_reg.ext_clock_engaged) |->
         ($past(st_reg.sw) == SW_ALIGN) && !$past(ext_level))
      else $error("engaged without two edges and low alignment");

   chk_ignore_modes: assert property (
      (switch_ignored && st_reg.sw == SW_INTERNAL) |=> (st_reg.sw == SW_INTERNAL))
      else $error("switch started in ignoring mode");

   chk_no_fallback: assert property (
      st_reg.ext_clock_engaged |=> st_reg.ext_clock_engaged)
      else $error("engaged status dropped without reset");

   chk_trim_write: assert property (
      (wr_in && addr_in == `OCS_INTERNAL_OSC_TRIM_ADDR) |=>
         (trim_factor_out == $past(wdata_in)))
      else $error("trim write not stored");

   chk_gen_enable_write: assert property (
      (wr_in && addr_in == `OCS_CLOCK_SWITCH_STATUS_ADDR) |=>
         (st_reg.ext_gen_enable == $past(wdata_in[`OCS_GEN_ENABLE_BIT])))
      else $error("generator enable write not stored");

   chk_read_idle: assert property (
      !rd_in |=> (rdata_out == `OCS_READ_IDLE))
      else $error("read data not idle outside a read");

   chk_status_read: assert property (
      (rd_in && addr_in == `OCS_CLOCK_SWITCH_STATUS_ADDR) |=>
         (rdata_out[`OCS_ENGAGED_BIT] == $past(st_reg.ext_clock_engaged)))
      else $error("status read does not show engaged state");

   chk_trim_reset: assert property (
      $rose(nrst_in) |-> (trim_factor_out == `OCS_TRIM_RESET) &&
         !st_reg.ext_clock_engaged)
      else $error("trim or status wrong after reset");

   chk_pin_clock: assert property (
      (pin_clock_output_enable_in && sel == `OCS_SEL_RC) |->
         (osc_pin2_oe_out && osc_pin2_out == clock_out_x4_out))
      else $error("second pin does not carry x4 clock");

endmodule // ocs_clock_select

// ==== ocs_far_side.sv ====
// External sources: crystal and RC run only while the design enables them
module ocs_far_side #(
   parameter int XTAL_HALF = 83,
   parameter int RC_HALF = 61,
   parameter int EXT_HALF = 43
) (
   // Oscillator enables from the design and a failure control
   input wire logic xtal_en_in,
   input wire logic rc_en_in,
   input wire logic dead_in,
   // Source clocks
   output logic xtal_out,
   output logic rc_out,
   output logic ext_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      xtal_out = 1'b0;
      rc_out = 1'b0;
      ext_out = 1'b0;
   end
   // A dead or disabled source stands low
   always #(XTAL_HALF) xtal_out = (xtal_en_in && !dead_in) ? ~xtal_out : 1'b0;
   always #(RC_HALF) rc_out = (rc_en_in && !dead_in) ? ~rc_out : 1'b0;
   always #(EXT_HALF) ext_out = dead_in ? 1'b0 : ~ext_out;
endmodule // ocs_far_side

// ==== ocs_pkg.sv ====
package ocs_pkg;

   // ----------------------------------------------------------------
   // Shared types
   // ----------------------------------------------------------------
   typedef logic [7:0] ocs_byte_t;

   // Internal to external switch sequence
   typedef enum logic [2:0] {
      SW_INTERNAL,
      SW_EDGE_ONE,
      SW_EDGE_TWO,
      SW_ALIGN,
      SW_EXTERNAL
   } ocs_sw_state_t;

   // Synchroniser state
   typedef struct packed {
      logic ff1;
      logic ff2;
      logic ff3;
      logic q;
   } ocs_sync_st_t;

   // Core state
   typedef struct packed {
      logic ext_gen_enable;
      logic ext_clock_engaged;
      logic [7:0] trim_factor;
      ocs_sw_state_t sw;
      logic int_level;
      logic [9:0] int_cnt;
      logic ext_prev;
      logic x4;
      logic x2;
      logic [7:0] rdata;
   } ocs_core_st_t;

endpackage

// ==== ocs_regs.svh ====
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define OCS_CLOCK_SWITCH_STATUS_ADDR 8'h36
`define OCS_INTERNAL_OSC_TRIM_ADDR 8'h38

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define OCS_ENGAGED_BIT 0
`define OCS_GEN_ENABLE_BIT 1
`define OCS_TRIM_RESET 8'h80
`define OCS_READ_IDLE 8'h00

// ----------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------
`define OCS_SEL_INTERNAL 2'h0
`define OCS_SEL_EXT_INPUT 2'h1
`define OCS_SEL_RC 2'h2
`define OCS_SEL_CRYSTAL 2'h3

// ----------------------------------------------------------------
// Internal oscillator timing
// ----------------------------------------------------------------
`define OCS_CLK_PERIOD_NS 10
`define OCS_INT_HALF_NS 5000
`define OCS_INT_HALF_CYC (`OCS_INT_HALF_NS / `OCS_CLK_PERIOD_NS)
`define OCS_TRIM_CENTER 10'h080
`define OCS_CNT_ONE 10'h001

`endif

// ==== ocs_sync.sv ====
// Three-stage pin synchroniser; output moves once stages two and three agree
module ocs_sync (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Asynchronous level and its filtered copy
   input wire logic async_in,
   output logic sync_out
);
   import ocs_pkg::*;

   ocs_sync_st_t st_reg;
   ocs_sync_st_t st_next;

   // Shift chain and agreement filter
   always_comb begin
      st_next = st_reg;
      st_next.ff1 = async_in;
      st_next.ff2 = st_reg.ff1;
      st_next.ff3 = st_reg.ff2;
      if (st_reg.ff2 == st_reg.ff3) begin
         st_next.q = st_reg.ff3;
      end
   end

   // State register
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.q;

endmodule // ocs_sync

// ==== tb_ocs_clock_select.sv ====
`include "ocs_regs.svh"

module tb_ocs_clock_select;
   timeunit 1ns;
   timeprecision 100ps;
   import ocs_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, osc_en = 1'b1, stop = 1'b0;
   logic sh = 1'b0, sl = 1'b0, mb = 1'b0, fa = 1'b0, fb = 1'b0, pe = 1'b1, dead = 1'b0;
   ocs_byte_t addr = 8'h00, wdata = 8'h00, rdata, trim;
   logic x4, x2, xtal, rc, ext, xen, ren, ien, iclk, p2, p2oe;
   int mismatches = 0, checks = 0;
   int half[4] = '{0, 43, 61, 83};

   // ----------------------------------------------------------------
   // Clock, design and far side
   // ----------------------------------------------------------------
   always #5 clk = ~clk;
   ocs_clock_select ocs_clock_select_inst (.core_clk_in(clk), .nrst_in(nrst), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .osc_enable_from_sysint_in(osc_en), .stop_mode_in(stop), .clock_out_x4_out(x4),
      .clock_out_x2_out(x2), .source_select_hi_in(sh), .source_select_lo_in(sl),
      .monitor_bypass_in(mb), .factory_test_mode_a_in(fa), .factory_test_mode_b_in(fb),
      .pin_clock_output_enable_in(pe), .crystal_source_clock_in(xtal),
      .rc_source_clock_in(rc), .ext_clock_pin_in(ext), .crystal_osc_enable_out(xen),
      .rc_osc_enable_out(ren), .internal_osc_enable_out(ien), .trim_factor_out(trim),
      .internal_source_clock_out(iclk), .osc_pin2_out(p2), .osc_pin2_oe_out(p2oe));
   ocs_far_side ocs_far_side_inst (.xtal_en_in(xen), .rc_en_in(ren), .dead_in(dead),
      .xtal_out(xtal), .rc_out(rc), .ext_out(ext));

   // ----------------------------------------------------------------
   // Bus tasks and comparisons
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      tick(1);
   endtask
   task automatic bus_wr(input ocs_byte_t a, input ocs_byte_t d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input ocs_byte_t a, output ocs_byte_t d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic cmp_byte(input ocs_byte_t got, input ocs_byte_t exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic rd_cmp(input ocs_byte_t a, input ocs_byte_t exp);
      ocs_byte_t d;
      bus_rd(a, d);
      cmp_byte(d, exp);
   endtask
   // Length of one high phase of the x4 output, in core cycles
   task automatic hi_run(output int n);
      int w;
      n = 0;
      w = 0;
      while (x4 !== 1'b0 && w < 3000) begin
         tick(1);
         w++;
      end
      while (x4 !== 1'b1 && w < 3000) begin
         tick(1);
         w++;
      end
      while (x4 === 1'b1 && w < 3000) begin
         tick(1);
         n++;
         w++;
      end
   endtask
   function automatic logic in_rng(input int n, input int lo, input int hi);
      return (n >= lo) && (n <= hi);
   endfunction
   task automatic report_and_stop();
      if (mismatches == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   initial begin
      #400us;
      mismatches++;
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      ocs_byte_t t;
      int n, r, c;
      logic p;
      void'($urandom(32'hbf77725a));
      do_reset();
      rd_cmp(`OCS_INTERNAL_OSC_TRIM_ADDR, `OCS_TRIM_RESET);
      rd_cmp(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h00);
      // Random trims read back; unmapped place ignored; engaged bit is read-only
      repeat (6) begin
         t = 8'($urandom());
         bus_wr(`OCS_INTERNAL_OSC_TRIM_ADDR, t);
         bus_wr(8'h37, ~t);
         rd_cmp(`OCS_INTERNAL_OSC_TRIM_ADDR, t);
         cmp_byte(trim, t);
         rd_cmp(8'h37, 8'h00);
      end
      bus_wr(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h01);
      rd_cmp(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h00);
      // Internal half period follows the trim value
      t = 8'h78 + 8'($urandom_range(16));
      bus_wr(`OCS_INTERNAL_OSC_TRIM_ADDR, t);
      hi_run(n);
      hi_run(n);
      cmp_bit(in_rng(n, 500 + int'(t) - 129, 500 + int'(t) - 127), 1'b1);
      cmp_bit(p2oe, 1'b1);
      cmp_bit(p2 === x4, 1'b1);
      // Stop halts the clocks and the internal oscillator
      @(posedge clk);
      stop <= 1'b1;
      pe <= 1'b0;
      tick(3);
      p = x2;
      for (int i = 0; i < 40; i++) begin
         tick(1);
         cmp_bit(x4 | (x2 ^ p) | ien | iclk, 1'b0);
      end
      cmp_bit(p2oe, 1'b0);
      @(posedge clk);
      stop <= 1'b0;
      pe <= 1'b1;
      osc_en <= 1'b0;
      tick(2);
      cmp_bit(ien, 1'b0);
      @(posedge clk);
      osc_en <= 1'b1;
      // Generator enable ignored in each ignore mode and with select 00
      for (int m = 0; m < 4; m++) begin
         do_reset();
         @(posedge clk);
         {sh, sl} <= (m == 3) ? 2'b00 : 2'b01;
         mb <= (m == 0);
         fa <= (m == 1);
         fb <= (m == 2);
         bus_wr(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h02);
         tick(120);
         rd_cmp(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h02);
         cmp_bit(ien, 1'b1);
      end
      @(posedge clk);
      {mb, fa, fb} <= 3'b000;
      // Switch to each external source in turn
      for (int s = 1; s < 4; s++) begin
         do_reset();
         @(posedge clk);
         {sh, sl} <= 2'(s);
         cmp_bit(ien, 1'b1);
         // Software waits for the source to settle
         tick(100);
         cmp_bit(xen, s == 3);
         cmp_bit(ren, s == 2);
         cmp_bit(p2oe, s == 2);
         bus_wr(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h02);
         r = 0;
         while (ien !== 1'b0 && r < 400) begin
            tick(1);
            r++;
         end
         rd_cmp(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h03);
         hi_run(n);
         hi_run(n);
         cmp_bit(in_rng(n, half[s] / 10, half[s] / 10 + 1), 1'b1);
         // x2 changes once for every x4 rise over 200 core cycles
         r = 0;
         c = 0;
         for (int i = 0; i < 200; i++) begin
            p = x2;
            t[0] = x4;
            tick(1);
            r += (x4 === 1'b1 && t[0] === 1'b0);
            c += (x2 !== p);
         end
         cmp_bit(in_rng(c - r, -1, 1) && r > 10, 1'b1);
      end
      // Clearing the bit or losing the source does not fall back
      bus_wr(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h00);
      @(posedge clk);
      dead <= 1'b1;
      tick(100);
      rd_cmp(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h01);
      cmp_bit(ien, 1'b0);
      @(posedge clk);
      dead <= 1'b0;
      do_reset();
      rd_cmp(`OCS_CLOCK_SWITCH_STATUS_ADDR, 8'h00);
      cmp_bit(ien, 1'b1);
      report_and_stop();
   end
endmodule // tb_ocs_clock_select
